// ==== src/mmc_top.sv ====
// Purpose: chooses who drives the modulation switches, divides the coil
//          rate reference and drives the alert output
// Assumes: pins arrive asynchronous; analog compare of the config pin and
//          the coil zero-cross are done outside and given as logic levels
// Notes:   open-drain outputs are two-signal (o and oe); enable low means driving
`timescale 1ns/100ps
`default_nettype none
module mmc_top
	import mmc_pkg::*;
#(
	parameter int unsigned GAP_LIMIT    = GAP_CYCLES,
	parameter int unsigned WINDOW_LIMIT = WINDOW_CYCLES,
	parameter int unsigned RCFG_W       = 20,
	parameter int unsigned TARGET_W     = 16
) (
	input  wire logic                clock,
	input  wire logic                resetn,
	input  wire logic                cfg_above_thresh,
	input  wire logic [RCFG_W-1:0]   cfg_resistor_ohm,
	input  wire logic                mcu_modulate,
	input  wire logic                internal_modulate,
	input  wire logic                coil_edge_in,
	input  wire logic                tx_alert_cmd,
	output logic [TARGET_W-1:0]      rectified_supply_target,
	output logic                     modulator_bypassed,
	output logic                     modulation_switch_one,
	output logic                     modulation_switch_two,
	output logic                     coil_rate_reference_o,
	output logic                     coil_rate_reference_oe,
	output logic                     mcu_interrupt_output_o,
	output logic                     mcu_interrupt_output_oe
);
	localparam int unsigned CNT_W = $clog2(WINDOW_LIMIT + 1);

	// mode register, declared early since the counters below read it
	mmc_mode_e mode_q;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic cfg_s, mod_s, coil_s, alert_s;

	mmc_sync u_cfg   (.clock(clock), .resetn(resetn), .async_in(cfg_above_thresh),  .sync_out(cfg_s));
	mmc_sync u_mod   (.clock(clock), .resetn(resetn), .async_in(mcu_modulate),      .sync_out(mod_s));
	mmc_sync u_coil  (.clock(clock), .resetn(resetn), .async_in(coil_edge_in),      .sync_out(coil_s));
	mmc_sync u_alert (.clock(clock), .resetn(resetn), .async_in(tx_alert_cmd),      .sync_out(alert_s));

	// ----------------------------------------------------------------
	// edge detection on synchronised levels
	// ----------------------------------------------------------------
	logic mod_prev_q, coil_prev_q;
	logic mod_rise, coil_rise;

	// previous values for edge detection
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mod_prev_q  <= 1'b0;
			coil_prev_q <= 1'b0;
		end else begin
			mod_prev_q  <= mod_s;
			coil_prev_q <= coil_s;
		end
	end

	assign mod_rise  = mod_s & ~mod_prev_q;
	assign coil_rise = coil_s & ~coil_prev_q;

	// ----------------------------------------------------------------
	// strap capture: config level taken once after reset release
	// ----------------------------------------------------------------
	logic strap_done_q, strap_cfg_q;

	// the strap settles through the sync, so wait for it to fill
	logic [1:0] strap_wait_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strap_wait_q <= 2'h0;
			strap_done_q <= 1'b0;
			strap_cfg_q  <= 1'b0;
		end else if (!strap_done_q) begin
			strap_wait_q <= strap_wait_q + 2'h1;
			if (strap_wait_q == 2'h3) begin
				strap_done_q <= 1'b1;
				strap_cfg_q  <= cfg_s;
			end
		end
	end

	// ----------------------------------------------------------------
	// takeover detection: gap timer and pulse run counter
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] gap_cnt_q;
	logic [3:0]       run_cnt_q;
	logic             run_full;

	// gap timer: cycles since the last rise, saturating at the limit
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			gap_cnt_q <= '0;
		end else if (mod_rise) begin
			gap_cnt_q <= '0;
		end else if (gap_cnt_q < CNT_W'(GAP_LIMIT)) begin
			gap_cnt_q <= gap_cnt_q + CNT_W'(1);
		end
	end

	// run counter lives only in stand-alone; clearing it elsewhere keeps an old
	// run from re-taking the switches the cycle after a stall hands them back
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			run_cnt_q <= PULSE_CNT_ZERO;
		end else if (mode_q != MMC_STANDALONE) begin
			run_cnt_q <= PULSE_CNT_ZERO;
		end else if (mod_rise) begin
			// a late pulse starts a new run of one
			if (run_cnt_q != PULSE_CNT_ZERO && gap_cnt_q >= CNT_W'(GAP_LIMIT))
				run_cnt_q <= 4'h1;
			else if (run_cnt_q < 4'(PULSE_COUNT))
				run_cnt_q <= run_cnt_q + 4'h1;
		end
	end

	assign run_full = (run_cnt_q == 4'(PULSE_COUNT));

	// ----------------------------------------------------------------
	// stall window: pulses counted per fixed 250 ms window
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] win_cnt_q;
	logic [3:0]       win_pulses_q;
	logic             win_end;

	assign win_end = (win_cnt_q == CNT_W'(WINDOW_LIMIT - 1));

	// window restarts on entry to bypass so the first look is full length
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			win_cnt_q    <= '0;
			win_pulses_q <= PULSE_CNT_ZERO;
		end else if (mode_q != MMC_BYPASS_TAKEN || win_end) begin
			win_cnt_q    <= '0;
			win_pulses_q <= PULSE_CNT_ZERO;
		end else begin
			win_cnt_q <= win_cnt_q + CNT_W'(1);
			if (mod_rise && win_pulses_q < 4'(PULSE_COUNT))
				win_pulses_q <= win_pulses_q + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// mode state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MMC_BYPASS_FIXED;
		end else begin
			case (mode_q)
				MMC_BYPASS_FIXED: begin
					// only a captured resistor strap leaves fixed bypass
					if (strap_done_q && strap_cfg_q)
						mode_q <= MMC_STANDALONE;
				end
				MMC_STANDALONE: begin
					if (run_full)
						mode_q <= MMC_BYPASS_TAKEN;
				end
				MMC_BYPASS_TAKEN: begin
					// a pulse landing on the window's last cycle still counts
					if (win_end && (win_pulses_q + {3'h0, mod_rise}) < 4'(PULSE_COUNT))
						mode_q <= MMC_STANDALONE;
				end
				default: mode_q <= MMC_BYPASS_FIXED;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// switch drive and supply target
	// ----------------------------------------------------------------
	logic sw_q;

	// switches close only while the selected source is signalling
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sw_q                    <= 1'b0;
			rectified_supply_target <= '0;
		end else begin
			if (mode_q == MMC_STANDALONE)
				sw_q <= internal_modulate;
			else
				sw_q <= mod_s;
			rectified_supply_target <= TARGET_W'(cfg_resistor_ohm / RCFG_W'(RCFG_DIVISOR));
		end
	end

	assign modulation_switch_one = sw_q;
	assign modulation_switch_two = sw_q;
	assign modulator_bypassed    = (mode_q != MMC_STANDALONE);

	// ----------------------------------------------------------------
	// coil rate reference: toggle every four rising edges
	// ----------------------------------------------------------------
	logic [1:0] div_cnt_q;
	logic       ref_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			div_cnt_q <= 2'h0;
			ref_q     <= 1'b0;
		end else if (coil_rise) begin
			div_cnt_q <= div_cnt_q + 2'h1;
			if (div_cnt_q == 2'(REF_DIVIDE / 2 - 1))
				ref_q <= ~ref_q;
		end
	end

	// open drain: pull low while reference is low
	assign coil_rate_reference_o  = 1'b0;
	assign coil_rate_reference_oe = ref_q;

	// ----------------------------------------------------------------
	// alert output: released from reset, low only on alert command
	// ----------------------------------------------------------------
	logic alert_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			alert_q <= 1'b0;
		else
			alert_q <= alert_s;
	end

	assign mcu_interrupt_output_o  = 1'b0;
	assign mcu_interrupt_output_oe = ~alert_q;
endmodule
`default_nettype wire

// ==== src/mmc_pkg.sv ====
// Purpose: shared constants for the modulator mode control block
// Assumes: 250 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derived here
package mmc_pkg;
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned GAP_MS         = 25;   // longest gap between takeover pulses
	localparam int unsigned WINDOW_MS      = 250;  // stall observation window
	localparam int unsigned PULSE_COUNT    = 8;    // pulses needed for takeover / to stay
	localparam int unsigned RCFG_DIVISOR   = 5000; // supply target = resistor / divisor
	localparam int unsigned CFG_THRESH_MV  = 250;  // configuration pin threshold
	localparam int unsigned REF_DIVIDE     = 8;    // coil reference division ratio
	localparam int unsigned MS_CYCLES      = CLK_MHZ * 1000;
	localparam int unsigned GAP_CYCLES     = GAP_MS * MS_CYCLES;
	localparam int unsigned WINDOW_CYCLES  = WINDOW_MS * MS_CYCLES;
	localparam logic [3:0]  PULSE_CNT_ZERO = 4'h0;

	typedef enum logic [1:0] {
		MMC_BYPASS_FIXED = 2'b00,
		MMC_STANDALONE   = 2'b01,
		MMC_BYPASS_TAKEN = 2'b10
	} mmc_mode_e;
endpackage

// ==== src/mmc_sync.sv ====
// Purpose: two-stage synchroniser for one level
// Assumes: single destination clock
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module mmc_sync (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta_q;

	// two flops, constant under reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_q   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== sim/mmc_chk_sva.sv ====
// Purpose: port-level assertions for mmc_top
// Assumes: bench drives inputs on the rising clock edge
// Notes:   bound into every mmc_top instance
`timescale 1ns/100ps
`default_nettype none
module mmc_chk (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic cfg_above_thresh,
	input  wire logic mcu_modulate,
	input  wire logic internal_modulate,
	input  wire logic coil_edge_in,
	input  wire logic tx_alert_cmd,
	input  wire logic modulator_bypassed,
	input  wire logic modulation_switch_one,
	input  wire logic modulation_switch_two,
	input  wire logic coil_rate_reference_oe,
	input  wire logic mcu_interrupt_output_oe
);
	// ----------------
	// helpers
	// ----------------
	logic [2:0] rise_q;
	logic       armed_q;
	logic [3:0] since_q;
	// coil rises per reference half period; the rise at a toggle opens the next window
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rise_q  <= 3'h0;
			armed_q <= 1'b0;
		end else if ($changed(coil_rate_reference_oe)) begin
			rise_q  <= {2'h0, $rose(coil_edge_in)};
			armed_q <= 1'b1;
		end else begin
			rise_q  <= rise_q + {2'h0, $rose(coil_edge_in)};
		end
	end
	// cycles since the last mcu rise, saturating so it never wraps into a false cause
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) since_q <= 4'hF;
		else if ($rose(mcu_modulate)) since_q <= 4'h0;
		else if (since_q != 4'hF) since_q <= since_q + 4'h1;
	end
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_SW_PAIR: assert property (modulation_switch_one == modulation_switch_two)
		else $error("switches differ");
	AST_FIXED_FOLLOW: assert property (modulator_bypassed && $past(modulator_bypassed, 4) && $stable(mcu_modulate)
		&& $past(mcu_modulate, 2) == mcu_modulate && $past(mcu_modulate, 3) == mcu_modulate
		|-> modulation_switch_one == mcu_modulate) else $error("switch not following mcu");
	AST_SOLO_FOLLOW: assert property (!modulator_bypassed && !$past(modulator_bypassed)
		|-> modulation_switch_one == $past(internal_modulate)) else $error("switch not following modulator");
	AST_REF_DIV: assert property ($changed(coil_rate_reference_oe) && armed_q |-> rise_q == 3'h4)
		else $error("reference ratio wrong");
	AST_ALERT_ON: assert property (tx_alert_cmd [*4] |-> !mcu_interrupt_output_oe)
		else $error("alert not driven");
	AST_ALERT_REL: assert property ((!tx_alert_cmd) [*4] |-> mcu_interrupt_output_oe)
		else $error("alert driven without command");
	AST_FIXED_MODE: assert property ((!cfg_above_thresh) [*8] |-> modulator_bypassed)
		else $error("fixed strap left bypass");
	AST_SOLO_START: assert property ($rose(resetn) && cfg_above_thresh |-> ##[3:8] !modulator_bypassed)
		else $error("no stand-alone after reset");
	AST_TAKE_CAUSE: assert property ($rose(modulator_bypassed) |-> since_q <= 4'hA)
		else $error("takeover without pulse");
	// main scenarios reached
	cover property ($rose(modulator_bypassed));
	cover property ($fell(modulator_bypassed));
	cover property ($fell(mcu_interrupt_output_oe));
endmodule
bind mmc_top mmc_chk mmc_chk_inst (.clock(clock), .resetn(resetn), .cfg_above_thresh(cfg_above_thresh),
	.mcu_modulate(mcu_modulate), .internal_modulate(internal_modulate), .coil_edge_in(coil_edge_in),
	.tx_alert_cmd(tx_alert_cmd), .modulator_bypassed(modulator_bypassed),
	.modulation_switch_one(modulation_switch_one), .modulation_switch_two(modulation_switch_two),
	.coil_rate_reference_oe(coil_rate_reference_oe), .mcu_interrupt_output_oe(mcu_interrupt_output_oe));
`default_nettype wire

// ==== sim/mmc_mcu_model.sv ====
// Purpose: receiver MCU model driving the modulation input
// Assumes: bench calls its tasks
// Notes:   levels change just after a rising edge only
`timescale 1ns/100ps
`default_nettype none
module mmc_mcu_model (
	input  wire logic clock,
	output var  logic mcu_modulate
);
	// ----------------
	// drive
	// ----------------
	// idle low, so a silent MCU never closes the switches
	initial mcu_modulate = 1'b0;
	// level held for n cycles, active high
	task automatic hold(input logic v, input int n);
		@(posedge clock);
		mcu_modulate <= v;
		repeat (n) @(posedge clock);
	endtask
	// burst of n pulses, one every gap+2 cycles, as power control traffic
	task automatic send(input int n, input int gap);
		repeat (n) begin
			hold(1'b1, 2);
			hold(1'b0, gap - 2);
		end
	endtask
endmodule
`default_nettype wire

// ==== sim/mmc_top_bench.sv ====
// Purpose: self-checking bench for mmc_top
// Assumes: gap 100 and window 1000 cycles stand in for the ms timers
// Notes:   coil runs at one tenth of the clock
`timescale 1ns/100ps
`default_nettype none
module mmc_top_bench;
	// ----------------
	// stimulus and checks
	// ----------------
	logic clock = 1'b0, resetn = 1'b0, strap = 1'b0, intm = 1'b0, coil = 1'b0, alert = 1'b0, mcu;
	logic byp, sw1, sw2, ref_o, ref_oe, irq_o, irq_oe;
	logic [15:0] target;
	logic [19:0] rcfg = 20'hEA60;
	int mismatches = 0, num_checks = 0;
	// clock and a free-running coil signal that t_ref measures
	initial begin
		forever #2 clock = ~clock;
	end
	always begin
		repeat (5) @(posedge clock);
		coil <= ~coil;
	end
	// watchdog: tests take about 3400 cycles, so 25000 leaves ample margin
	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end
	mmc_top #(.GAP_LIMIT(100), .WINDOW_LIMIT(1000)) mmc_top_inst (.clock(clock), .resetn(resetn),
		.cfg_above_thresh(strap), .cfg_resistor_ohm(rcfg), .mcu_modulate(mcu), .internal_modulate(intm),
		.coil_edge_in(coil), .tx_alert_cmd(alert), .rectified_supply_target(target), .modulator_bypassed(byp),
		.modulation_switch_one(sw1), .modulation_switch_two(sw2), .coil_rate_reference_o(ref_o),
		.coil_rate_reference_oe(ref_oe), .mcu_interrupt_output_o(irq_o), .mcu_interrupt_output_oe(irq_oe));
	mmc_mcu_model mmc_mcu_model_inst (.clock(clock), .mcu_modulate(mcu));
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// reset held for 8 cycles; strap set while reset holds so release captures it
	task do_reset(input logic s);
		cyc(1);
		resetn <= 1'b0;
		strap  <= s;
		intm   <= 1'b0;
		alert  <= 1'b0;
		cyc(4);
		@(negedge clock);
		chk("alert in reset", irq_oe, 1'b1);
		cyc(4);
		resetn <= 1'b1;
		cyc(10);
	endtask
	// grounded strap: mcu owns the switches, pulses never change mode
	task t_fixed;
		do_reset(1'b0);
		intm <= 1'b1;
		mmc_mcu_model_inst.send(10, 20);
		@(negedge clock);
		chk("fixed mode", byp, 1'b1);
		chk("modulator ignored", sw1, 1'b0);
		mmc_mcu_model_inst.hold(1'b1, 6);
		@(negedge clock);
		chk("mcu high", sw1, 1'b1);
		mmc_mcu_model_inst.hold(1'b0, 6);
		intm <= 1'b0;
		$display("fixed bypass test done");
	endtask
	// strap high: modulator owns switches, target is resistor over divisor
	task t_solo;
		do_reset(1'b1);
		@(negedge clock);
		chk("stand-alone", byp, 1'b0);
		chk("target", target, 16'h000C);
		cyc(1);
		rcfg <= 20'h1D4C0;
		cyc(2);
		@(negedge clock);
		chk("target two", target, 16'h0018);
		cyc(1);
		intm <= 1'b1;
		cyc(3);
		@(negedge clock);
		chk("sw two closed", sw2, 1'b1);
		cyc(1);
		intm <= 1'b0;
		cyc(2);
		@(negedge clock);
		chk("sw two open", sw2, 1'b0);
		$display("stand-alone test done");
	endtask
	// seven pulses, a late restart, the eighth; busy traffic holds; then a stall
	task t_take;
		mmc_mcu_model_inst.send(7, 20);
		@(negedge clock);
		chk("seven pulses", byp, 1'b0);
		cyc(150);
		mmc_mcu_model_inst.send(7, 20);
		@(negedge clock);
		chk("late restart", byp, 1'b0);
		mmc_mcu_model_inst.send(1, 20);
		@(negedge clock);
		chk("takeover", byp, 1'b1);
		mmc_mcu_model_inst.hold(1'b1, 6);
		@(negedge clock);
		chk("mcu drives", sw1, 1'b1);
		mmc_mcu_model_inst.hold(1'b0, 2);
		// about forty pulses per window keep the mcu in charge past one window
		mmc_mcu_model_inst.send(45, 22);
		@(negedge clock);
		chk("busy stays", byp, 1'b1);
		cyc(1100);
		@(negedge clock);
		chk("stall return", byp, 1'b0);
		cyc(1);
		intm <= 1'b1;
		cyc(2);
		@(negedge clock);
		chk("modulator back", sw1, 1'b1);
		cyc(1);
		intm <= 1'b0;
		$display("takeover test done");
	endtask
	task t_alert;
		cyc(1);
		alert <= 1'b1;
		cyc(4);
		@(negedge clock);
		chk("alert low", irq_oe, 1'b0);
		chk("alert level", irq_o, 1'b0);
		cyc(1);
		alert <= 1'b0;
		cyc(4);
		@(negedge clock);
		chk("alert released", irq_oe, 1'b1);
		$display("alert test done");
	endtask
	// 400 cycles hold 40 coil periods, so 10 reference half periods
	task t_ref;
		int t;
		logic p;
		t = 0;
		p = ref_oe;
		repeat (400) begin
			@(negedge clock);
			if (ref_oe !== p) t++;
			p = ref_oe;
		end
		chk("ref toggles", t[15:0], 16'h000A);
		chk("ref level", ref_o, 1'b0);
		$display("reference test done");
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		t_fixed;
		t_solo;
		t_take;
		t_alert;
		t_ref;
		report_and_stop();
	end
endmodule
`default_nettype wire
